/* File: verilog/machine_status_word_unit.sv */
// status word register, field decode, masking and apb access
//
// Contract
// - one 64-bit status word holds address, flags, masks and control fields
// - taking an interrupt saves the current word as old word; registers not saved
// - every mask bit: zero inhibits its interrupt, one allows it
// - next instruction address built from bits 0-15 and 24-27
// - bits 16-17 hold the two-bit condition code
// - bit 18 is the carry indicator
// - bit 19 is overflow, cleared on test or on word load; a word load here copies bit 19 from the new word
// - bit 20 masks fixed overflow, 21 reserved, 22 underflow, 23 significance
// - branch address msb one uses bits 24-27, otherwise sector 0000
// - data address msb one uses bits 28-31 as sector
// - bits 32-39 system mask: counters, monitor, five external/timer masks
// - a set-mask instruction rewrites only the system mask
// - supervisor call saves 4-bit address extension in old bits 40-43
// - bit 44 selects register set, effective on every word load
// - bit 45 zero inhibits machine check interrupts
// - wait bit: zero process state, one wait state
// - problem bit: zero supervisor, one problem state
// - bits 48 up take interrupt code, or operand address for supervisor call
// - system mask gates external interrupts 0 to 4 individually
// - privileged instructions run only in supervisor state
// - unprotected fetch raises monitor interrupt when bit 34 set; address not advanced
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "msw_cfg.svh"

module machine_status_word_unit (
   // clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // apb slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [11:0]                   paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // sequencer requests
   input  wire msw_pkg::seq_req_s             seq_req,
   input  wire msw_pkg::int_take_s            int_take,
   // address generation
   input  wire logic [15:0]                   branch_addr,
   input  wire logic [15:0]                   data_addr,
   output logic      [18:0]                   nia_ea,
   output logic      [18:0]                   branch_ea,
   output logic      [18:0]                   data_ea,
   // interrupt requests and gated result
   input  wire msw_pkg::irq_s                 irq_req,
   input  wire logic                          fetch_unprotected,
   output msw_pkg::irq_s                      irq_ok,
   // status to the rest of the cpu
   output msw_pkg::machine_status_word_s      cur_word,
   output msw_pkg::machine_status_word_s      old_word,
   output logic                               general_register_set,
   output logic                               wait_state,
   output logic                               problem_state,
   output logic                               priv_error
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // replaces the msb of a 16-bit address by a 4-bit sector
   function automatic logic [18:0] form_ea(input logic [3:0]  sector,
                                           input logic [15:0] addr);
      form_ea = {sector, addr[14:0]};
   endfunction

   // branch style sector pick: msb one uses the sector, else zero
   function automatic logic [18:0] sector_ea(input logic [3:0]  sector,
                                             input logic [15:0] addr);
      if (addr[15]) begin
         sector_ea = form_ea(sector, addr);
      end else begin
         sector_ea = form_ea(`MSW_SECTOR_ZERO, addr);
      end
   endfunction

   msw_pkg::msw_state_s st_r;
   msw_pkg::msw_state_s st_nxt;

   logic [63:0] cur_bits;
   logic [63:0] old_bits;
   logic        bus_setup;
   logic        bus_write;
   logic        supervisor;
   logic        monitor_hit;

   assign cur_bits    = st_r.cur;
   assign old_bits    = st_r.old;
   assign bus_setup   = psel && !penable;
   assign bus_write   = psel && penable && pwrite && st_r.pready;
   assign supervisor  = !st_r.cur.problem;
   assign monitor_hit = fetch_unprotected && st_r.cur.sys_mask[5];

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [63:0] wr_bits;
      wr_bits = cur_bits;
      st_nxt  = st_r;

      // apb: data captured in setup, answer in the first access cycle
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
      if (bus_setup) begin
         st_nxt.pready = 1'b1;
         st_nxt.prdata = 32'h0000_0000;
         if (paddr == `MSW_OFF_CUR_HI) begin
            st_nxt.prdata = cur_bits[63:32];
         end else if (paddr == `MSW_OFF_CUR_LO) begin
            st_nxt.prdata = cur_bits[31:0];
         end else if (paddr == `MSW_OFF_OLD_HI) begin
            st_nxt.prdata = old_bits[63:32];
         end else if (paddr == `MSW_OFF_OLD_LO) begin
            st_nxt.prdata = old_bits[31:0];
         end else if (paddr == `MSW_OFF_STATE) begin
            st_nxt.prdata[`MSW_ST_WAIT]    = st_r.cur.wait_st;
            st_nxt.prdata[`MSW_ST_PROBLEM] = st_r.cur.problem;
            st_nxt.prdata[`MSW_ST_REGSET]  = st_r.cur.reg_set;
            st_nxt.prdata[`MSW_ST_PRIVERR] = st_r.priv_err;
         end else begin
            st_nxt.pslverr = 1'b1;
         end
      end

      // sequencer flag updates
      if (seq_req.advance) begin
         st_nxt.cur.next_addr = seq_req.next_addr;
      end
      if (seq_req.set_flags) begin
         st_nxt.cur.cond_code = seq_req.cond_code;
         st_nxt.cur.carry     = seq_req.carry;
      end
      // a test clears overflow, but a new overflow in the same cycle wins
      if (seq_req.ovf_test) begin
         st_nxt.cur.overflow = 1'b0;
      end
      if (seq_req.ovf_set) begin
         st_nxt.cur.overflow = 1'b1;
      end

      // privileged operations are refused in problem state
      st_nxt.priv_err = seq_req.priv_op && !supervisor;
      if (seq_req.mask_set && supervisor) begin
         st_nxt.cur.sys_mask = seq_req.mask_val;
      end
      if (seq_req.status_load_instruction && supervisor) begin
         // whole word at once; overflow comes from the new word
         st_nxt.cur = seq_req.load_val;
      end

      // software write over apb loads one half of the current word
      if (bus_write && paddr == `MSW_OFF_CUR_HI) begin
         wr_bits[63:32] = pwdata;
         st_nxt.cur     = wr_bits;
      end else if (bus_write && paddr == `MSW_OFF_CUR_LO) begin
         wr_bits[31:0] = pwdata;
         st_nxt.cur    = wr_bits;
      end

      // interrupt swap has highest priority; general registers are left alone
      if (int_take.take) begin
         st_nxt.old = st_r.cur;
         if (int_take.supervisor_call) begin
            st_nxt.old.ea_high  = int_take.ea_high;
            st_nxt.old.int_code = int_take.operand_effective_address;
         end else if (int_take.code_valid) begin
            st_nxt.old.int_code = int_take.code;
         end
         // monitor hit: address is not advanced, old word names the culprit
         if (monitor_hit) begin
            st_nxt.old.next_addr = st_r.cur.next_addr;
         end
         st_nxt.cur = int_take.new_word;
      end

      // address formation
      st_nxt.nia_ea    = sector_ea(st_r.cur.branch_sector_field,
                                   st_r.cur.next_addr);
      st_nxt.branch_ea = sector_ea(st_r.cur.branch_sector_field,
                                   branch_addr);
      // msb zero data addresses go on to expanded addressing untouched
      st_nxt.data_ea   = data_addr[15] ?
                         form_ea(st_r.cur.data_sector, data_addr) :
                         {`MSW_SECTOR_ZERO, data_addr[14:0]};

      // interrupt gating, one allows, zero inhibits
      st_nxt.irq_ok.fxo     = irq_req.fxo && st_r.cur.fxo_mask;
      st_nxt.irq_ok.fpu     = irq_req.fpu && st_r.cur.fpu_mask;
      st_nxt.irq_ok.sig     = irq_req.sig && st_r.cur.sig_mask;
      st_nxt.irq_ok.counter = irq_req.counter & st_r.cur.sys_mask[7:6];
      st_nxt.irq_ok.monitor = (irq_req.monitor && st_r.cur.sys_mask[5])
                              || monitor_hit;
      st_nxt.irq_ok.ext     = irq_req.ext & st_r.cur.sys_mask[4:0];
      st_nxt.irq_ok.mchk    = irq_req.mchk && st_r.cur.mchk_mask;
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------
   assign prdata               = st_r.prdata;
   assign pready               = st_r.pready;
   assign pslverr              = st_r.pslverr;
   assign nia_ea               = st_r.nia_ea;
   assign branch_ea            = st_r.branch_ea;
   assign data_ea              = st_r.data_ea;
   assign irq_ok               = st_r.irq_ok;
   assign cur_word             = st_r.cur;
   assign old_word             = st_r.old;
   assign general_register_set = st_r.cur.reg_set;
   assign wait_state           = st_r.cur.wait_st;
   assign problem_state        = st_r.cur.problem;
   assign priv_error           = st_r.priv_err;

endmodule

/* File: common/msw_cfg.svh */
// constants for the machine status word unit
`ifndef MSW_CFG_SVH
`define MSW_CFG_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define MSW_OFF_CUR_HI  12'h000
`define MSW_OFF_CUR_LO  12'h004
`define MSW_OFF_OLD_HI  12'h008
`define MSW_OFF_OLD_LO  12'h00c
`define MSW_OFF_STATE   12'h010

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define MSW_W           64
`define MSW_ADDR_W      16
`define MSW_EA_W        19
`define MSW_SECTOR_W    4
`define MSW_SMASK_W     8
`define MSW_RESET       64'h0000_0000_0000_0000
`define MSW_SECTOR_ZERO 4'h0

// ----------------------------------------
// state register bit positions
// ----------------------------------------
`define MSW_ST_WAIT     0
`define MSW_ST_PROBLEM  1
`define MSW_ST_REGSET   2
`define MSW_ST_PRIVERR  3

`endif

/* File: common/msw_pkg.sv */
// types for the machine status word unit
package msw_pkg;

   // ----------------------------------------
   // status word, bit 0 (leftmost) is the msb
   // ----------------------------------------
   typedef struct packed {
      logic [15:0] next_addr;     // bits 0-15
      logic [1:0]  cond_code;     // 16-17
      logic        carry;         // 18
      logic        overflow;      // 19
      logic        fxo_mask;      // 20
      logic        rsvd21;        // 21
      logic        fpu_mask;      // 22
      logic        sig_mask;      // 23
      logic [3:0]  branch_sector_field; // 24-27
      logic [3:0]  data_sector;   // 28-31
      logic [7:0]  sys_mask;      // 32-39
      logic [3:0]  ea_high;       // 40-43
      logic        reg_set;       // 44
      logic        mchk_mask;     // 45
      logic        wait_st;       // 46
      logic        problem;       // 47
      logic [15:0] int_code;      // 48-63
   } machine_status_word_s;

   // ----------------------------------------
   // requests from the sequencer
   // ----------------------------------------
   typedef struct packed {
      logic                 advance;
      logic [15:0]          next_addr;
      logic                 set_flags;
      logic [1:0]           cond_code;
      logic                 carry;
      logic                 ovf_set;
      logic                 ovf_test;
      logic                 mask_set;
      logic [7:0]           mask_val;
      logic                 status_load_instruction;
      machine_status_word_s load_val;
      logic                 priv_op;
   } seq_req_s;

   typedef struct packed {
      logic                 take;
      machine_status_word_s new_word;
      logic                 code_valid;
      logic [15:0]          code;
      logic                 supervisor_call;
      logic [3:0]           ea_high;
      logic [15:0]          operand_effective_address;
   } int_take_s;

   // interrupt classes gated by mask bits
   typedef struct packed {
      logic       fxo;
      logic       fpu;
      logic       sig;
      logic [1:0] counter;
      logic       monitor;
      logic [4:0] ext;
      logic       mchk;
   } irq_s;

   // ----------------------------------------
   // whole state of the unit
   // ----------------------------------------
   typedef struct packed {
      machine_status_word_s cur;
      machine_status_word_s old;
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
      logic [18:0]          nia_ea;
      logic [18:0]          branch_ea;
      logic [18:0]          data_ea;
      irq_s                 irq_ok;
      logic                 priv_err;
   } msw_state_s;

endpackage

/* File: verification/msw_asserts.sv */
// concurrent checks on the status word unit ports
`timescale 1ns/10ps
module msw_asserts (
   // clock and reset
   input wire logic                          pclk,
   input wire logic                          presetn,
   // apb and requests
   input wire logic                          psel,
   input wire logic                          penable,
   input wire logic                          pwrite,
   input wire msw_pkg::seq_req_s             seq_req,
   input wire msw_pkg::int_take_s            int_take,
   input wire logic [15:0]                   branch_addr,
   input wire logic [15:0]                   data_addr,
   input wire msw_pkg::irq_s                 irq_req,
   input wire logic                          fetch_unprotected,
   // design outputs
   input wire logic [18:0]                   branch_ea,
   input wire logic [18:0]                   data_ea,
   input wire msw_pkg::irq_s                 irq_ok,
   input wire msw_pkg::machine_status_word_s cur_word,
   input wire msw_pkg::machine_status_word_s old_word,
   input wire logic                          general_register_set,
   input wire logic                          priv_error
);
   // higher-priority writers must be absent for the lower ones to land
   wire quiet = !int_take.take && !(psel && penable && pwrite);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ovf_test_clear: assert property (seq_req.ovf_test && !seq_req.ovf_set && quiet
      && !seq_req.status_load_instruction |=> !cur_word.overflow) else $error("overflow kept");
   a_arith_ext_gate: assert property ($past(presetn) |-> irq_ok.fxo ==
      $past(irq_req.fxo & cur_word.fxo_mask) && irq_ok.ext == $past(irq_req.ext &
      cur_word.sys_mask[4:0])) else $error("mask gating wrong");
   a_count_mchk_gate: assert property ($past(presetn) |-> irq_ok.counter ==
      $past(irq_req.counter & cur_word.sys_mask[7:6]) && irq_ok.mchk ==
      $past(irq_req.mchk & cur_word.mchk_mask)) else $error("counter or check gating wrong");
   a_monitor_hit: assert property (fetch_unprotected && cur_word.sys_mask[5]
      |=> irq_ok.monitor) else $error("monitor hit lost");
   a_int_save_word: assert property (int_take.take |=> cur_word == $past(int_take.new_word)
      && old_word.next_addr == $past(cur_word.next_addr) && old_word.sys_mask ==
      $past(cur_word.sys_mask)) else $error("interrupt swap wrong");
   a_svc_save_fields: assert property (int_take.take && int_take.supervisor_call
      |=> old_word.ea_high == $past(int_take.ea_high) && old_word.int_code ==
      $past(int_take.operand_effective_address)) else $error("call fields wrong");
   a_priv_flag: assert property (seq_req.priv_op && cur_word.problem |=> priv_error)
      else $error("privilege error missing");
   a_priv_refused: assert property ((seq_req.status_load_instruction || seq_req.mask_set)
      && cur_word.problem && quiet |=> $stable(cur_word.sys_mask) && cur_word.problem)
      else $error("privileged load obeyed");
   a_load_all: assert property (seq_req.status_load_instruction && !cur_word.problem
      && quiet |=> cur_word == $past(seq_req.load_val) && general_register_set ==
      $past(seq_req.load_val.reg_set)) else $error("word load incomplete");
   a_mask_only: assert property (seq_req.mask_set && !cur_word.problem && quiet &&
      !seq_req.status_load_instruction |=> cur_word.sys_mask == $past(seq_req.mask_val)
      && $stable(cur_word.int_code) && $stable(cur_word.mchk_mask)) else $error("mask set wrong");
   a_sector_subst: assert property ($past(presetn) |-> branch_ea == $past(branch_addr[15] ?
      {cur_word.branch_sector_field, branch_addr[14:0]} : {4'h0, branch_addr[14:0]}) &&
      ($past(data_addr[15]) -> data_ea == $past({cur_word.data_sector, data_addr[14:0]})))
      else $error("sector substitution wrong");
endmodule
bind machine_status_word_unit msw_asserts i_msw_asserts (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .seq_req(seq_req), .int_take(int_take),
   .branch_addr(branch_addr), .data_addr(data_addr), .irq_req(irq_req),
   .fetch_unprotected(fetch_unprotected), .branch_ea(branch_ea), .data_ea(data_ea),
   .irq_ok(irq_ok), .cur_word(cur_word), .old_word(old_word),
   .general_register_set(general_register_set), .priv_error(priv_error));

/* File: verification/msw_seq_model.sv */
// sequencer and interrupt side model driving the status word unit
`timescale 1ns/10ps
module msw_seq_model (
   // clock
   input  wire logic          pclk,
   // requests
   output msw_pkg::seq_req_s  seq_req,
   output msw_pkg::int_take_s int_take
);
   initial begin
      seq_req = '0;
      int_take = '0;
   end
   // every request is a single-cycle pulse, so a held bit would act twice
   task automatic seq(input msw_pkg::seq_req_s r);
      @(posedge pclk);
      seq_req <= r;
      @(posedge pclk);
      seq_req <= '0;
   endtask
   task automatic irq(input msw_pkg::int_take_s t);
      @(posedge pclk);
      int_take <= t;
      @(posedge pclk);
      int_take <= '0;
   endtask
endmodule

/* File: verification/machine_status_word_unit_tb_top.sv */
// self-checking bench for the status word unit
`timescale 1ns/10ps
`include "msw_cfg.svh"
module machine_status_word_unit_tb_top;
   logic                          pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic                          fetch_unprotected, general_register_set;
   logic                          wait_state, problem_state, priv_error;
   logic [11:0]                   paddr;
   logic [31:0]                   pwdata, prdata, q;
   logic [15:0]                   branch_addr, data_addr;
   logic [18:0]                   branch_ea, data_ea, nia_ea;
   msw_pkg::irq_s                 irq_req, irq_ok;
   msw_pkg::machine_status_word_s cur_word, old_word;
   msw_pkg::seq_req_s             seq_req, r;
   msw_pkg::int_take_s            int_take, t;
   int                            num_errors, n_compared;
   machine_status_word_unit i_machine_status_word_unit (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_req(seq_req),
      .int_take(int_take), .branch_addr(branch_addr), .data_addr(data_addr), .nia_ea(nia_ea),
      .branch_ea(branch_ea), .data_ea(data_ea), .irq_req(irq_req),
      .fetch_unprotected(fetch_unprotected), .irq_ok(irq_ok), .cur_word(cur_word),
      .old_word(old_word), .general_register_set(general_register_set),
      .wait_state(wait_state), .problem_state(problem_state), .priv_error(priv_error));
   msw_seq_model i_msw_seq_model (.pclk(pclk), .seq_req(seq_req), .int_take(int_take));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic conclude;
      if (num_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // answer captured while pready stands, released at the edge that samples it
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      #1;
      n = 0;
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         #1;
         n++;
      end
      if (n == 20) begin
         num_errors++;
         conclude();
      end
      q = prdata;
      e = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // ----------------------------------------
   // clock and sequence
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, fetch_unprotected} = '0;
      {paddr, pwdata, branch_addr, data_addr, irq_req, r, t} = '0;
      num_errors = 0;
      n_compared = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `MSW_OFF_CUR_LO, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk(e, 1'b1);
      apb(1'b1, `MSW_OFF_CUR_HI, 32'h1234_fba5);
      apb(1'b0, `MSW_OFF_CUR_HI, 32'h0);
      chk(q, 32'h1234_fba5);
      r.ovf_test = 1'b1;
      i_msw_seq_model.seq(r);
      apb(1'b0, `MSW_OFF_CUR_HI, 32'h0);
      chk(q, 32'h1234_eba5);
      apb(1'b1, `MSW_OFF_CUR_LO, 32'hffcc_0000);
      branch_addr <= 16'h8003;
      data_addr <= 16'h8004;
      irq_req <= '1;
      fetch_unprotected <= 1'b1;
      repeat (3) @(posedge pclk);
      #1;
      chk(branch_ea, {4'ha, 15'h0003});
      chk(data_ea, {4'h5, 15'h0004});
      chk(nia_ea, {4'h0, 15'h1234});
      chk(irq_ok, 12'hfff);
      chk(general_register_set, 1'b1);
      branch_addr <= 16'h0003;
      r = '0;
      r.mask_set = 1'b1;
      i_msw_seq_model.seq(r);
      repeat (3) @(posedge pclk);
      #1;
      chk(branch_ea, {4'h0, 15'h0003});
      chk(irq_ok, 12'he01);
      apb(1'b0, `MSW_OFF_CUR_LO, 32'h0);
      chk(q, 32'h00cc_0000);
      t.take = 1'b1;
      t.new_word = 64'h0000_0000_0001_0000;
      t.supervisor_call = 1'b1;
      t.ea_high = 4'h9;
      t.operand_effective_address = 16'hbeef;
      i_msw_seq_model.irq(t);
      #1;
      chk(cur_word, 64'h0000_0000_0001_0000);
      chk(problem_state, 1'b1);
      apb(1'b1, `MSW_OFF_OLD_HI, 32'hffff_ffff);
      apb(1'b0, `MSW_OFF_OLD_HI, 32'h0);
      chk(q, 32'h1234_eba5);
      apb(1'b0, `MSW_OFF_OLD_LO, 32'h0);
      chk(q, 32'h009c_beef);
      r = '0;
      r.status_load_instruction = 1'b1;
      r.load_val = '1;
      r.priv_op = 1'b1;
      fork
         i_msw_seq_model.seq(r);
         begin
            repeat (2) @(posedge pclk);
            #1;
            chk(priv_error, 1'b1);
            chk(cur_word, 64'h0000_0000_0001_0000);
         end
      join
      apb(1'b1, `MSW_OFF_CUR_LO, 32'h0);
      r = '0;
      r.status_load_instruction = 1'b1;
      r.load_val = 64'h0000_0000_000a_0000;
      i_msw_seq_model.seq(r);
      #1;
      chk(cur_word, 64'h0000_0000_000a_0000);
      chk({general_register_set, wait_state, problem_state}, 3'b110);
      conclude();
   end
endmodule
